// >>> rtl/fag_pkg.sv
// Constants for the flash identifier authentication gate
`default_nettype none
package fag_pkg;
  // Setting location in flash and its layout
  localparam logic [31:0] SET_BASE = 32'h0fffffa0;
  localparam logic [31:0] SET_STRIDE = 32'h00000004;
  localparam int SET_WORDS = 4;
  localparam int CTRL_MSB = 31;
  localparam int CTRL_LSB = 24;
  localparam int ID_BITS = 120;
  // Control codes
  localparam logic [7:0] CODE_OPEN_ID = 8'h52;
  localparam logic [7:0] CODE_ERASE_FAIL = 8'h45;
  // Lock identifier pattern, first byte in the top bits
  localparam logic [119:0] LOCK_ID = {56'h50726f74656374, 64'hffffffffffffffff};
  // Failed attempts before erase
  localparam logic [1:0] FAIL_LIMIT = 2'h3;
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h08;
  localparam logic [7:0] OFS_IRQ_EN = 8'h0c;
  localparam logic [7:0] OFS_AW_START = 8'h10;
  localparam logic [7:0] OFS_AW_END = 8'h14;
  localparam logic [7:0] OFS_AW_CTRL = 8'h18;
  localparam logic [7:0] OFS_CTRL_CODE = 8'h1c;
  // Interrupt event bits
  localparam int EV_PASS = 0;
  localparam int EV_FAIL = 1;
  localparam int EV_ERASE = 2;
  localparam int EV_ERASED = 3;
  localparam int EV_W = 4;
  // Protection modes and state encodings
  typedef enum logic [1:0] {MODE_ERASE_ALWAYS, MODE_ERASE_FAIL, MODE_OPEN_ID, MODE_LOCKED} fag_mode_t;
  typedef enum logic [2:0] {BS_IDLE, BS_AUTH, BS_ERASE, BS_OPEN} fag_boot_t;
  typedef enum logic [1:0] {DS_IDLE, DS_AUTH, DS_OPEN} fag_dbg_t;
  typedef enum logic [1:0] {LD_REQ, LD_WAIT, LD_DONE} fag_load_t;
endpackage
`default_nettype wire

// >>> rtl/fag_gate.sv
// Flash identifier authentication gate with AHB-Lite registers
//
// Function
// R1: Open-ID setting requires boot identifier authentication
// R2: Boot match opens read, program, erase
// R3: Boot mismatch denies and awaits retry
// R4: Debugger authenticated alike, retry on mismatch
// R5: Lock pattern makes every identifier mismatch
// R6: Lock after reset cannot be removed
// R7: Setting is control byte plus fifteen bytes
// R8: Setting fetched from fixed flash address
// R9: Four words, control byte topmost first
// R10: Host must present stored identifier
// R11: Boot host authenticated after boot startup
// R12: Debugger authenticated after single-chip startup
// R13: Access window blocks program outside it
// R14: Other codes erase boot, authenticate debugger
// R15: Erase-fail code erases after three failures
// R16: Match only when all fifteen bytes equal
`default_nettype none
module fag_gate #(
  parameter int AW_W = 32
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Setting fetch from flash
  output logic FLASH_RD_REQ,
  output logic [31:0] FLASH_RD_ADDR,
  input wire logic [31:0] FLASH_RD_DATA,
  input wire logic FLASH_RD_VALID,
  // Connections and identifier presentation
  input wire logic BOOT_CONN,
  input wire logic DBG_CONN,
  input wire logic AUTH_REQ,
  input wire logic AUTH_DBG,
  input wire logic [119:0] AUTH_ID,
  output logic AUTH_DONE,
  output logic AUTH_OK,
  // Flash rights and erase
  output logic BOOT_ACCESS,
  output logic DBG_LINK,
  output logic ERASE_REQ,
  input wire logic ERASE_DONE,
  // Program and erase window check
  input wire logic [AW_W-1:0] PE_ADDR,
  output logic PE_BLOCK,
  // Interrupt
  output logic IRQ
);

  function automatic logic [31:0] word_addr(input logic [1:0] idx);
    word_addr = fag_pkg::SET_BASE + fag_pkg::SET_STRIDE * {30'h0, idx};
  endfunction

  // Setting load state
  fag_pkg::fag_load_t ld_r, ld_nxt;
  logic [1:0] widx_r, widx_nxt;
  logic [31:0] w0_r, w0_nxt, w1_r, w1_nxt, w2_r, w2_nxt, w3_r, w3_nxt;

  // R8: fixed address fetch
  always_comb begin
    ld_nxt = ld_r;
    widx_nxt = widx_r;
    w0_nxt = w0_r;
    w1_nxt = w1_r;
    w2_nxt = w2_r;
    w3_nxt = w3_r;
    case (ld_r)
      fag_pkg::LD_REQ: begin
        ld_nxt = fag_pkg::LD_WAIT;
      end
      fag_pkg::LD_WAIT: begin
        if (FLASH_RD_VALID) begin
          case (widx_r)
            2'h0: w0_nxt = FLASH_RD_DATA;
            2'h1: w1_nxt = FLASH_RD_DATA;
            2'h2: w2_nxt = FLASH_RD_DATA;
            default: w3_nxt = FLASH_RD_DATA;
          endcase
          widx_nxt = widx_r + 2'h1;
          ld_nxt = (widx_r == 2'(fag_pkg::SET_WORDS - 1)) ? fag_pkg::LD_DONE : fag_pkg::LD_REQ;
        end
      end
      fag_pkg::LD_DONE: begin
        ld_nxt = fag_pkg::LD_DONE;
      end
      default: begin
        ld_nxt = fag_pkg::LD_REQ;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      ld_r <= fag_pkg::LD_REQ;
      widx_r <= 2'h0;
      w0_r <= 32'h0;
      w1_r <= 32'h0;
      w2_r <= 32'h0;
      w3_r <= 32'h0;
    end else begin
      ld_r <= ld_nxt;
      widx_r <= widx_nxt;
      w0_r <= w0_nxt;
      w1_r <= w1_nxt;
      w2_r <= w2_nxt;
      w3_r <= w3_nxt;
    end
  end

  assign FLASH_RD_REQ = (ld_r == fag_pkg::LD_REQ);
  assign FLASH_RD_ADDR = word_addr(widx_r);

  // R7: control byte and identifier
  // R9: control byte topmost, bytes in order
  logic loaded;
  logic [7:0] ctrl_code;
  logic [119:0] stored_id;
  fag_pkg::fag_mode_t mode;
  assign loaded = (ld_r == fag_pkg::LD_DONE);
  assign ctrl_code = w0_r[fag_pkg::CTRL_MSB:fag_pkg::CTRL_LSB];
  assign stored_id = {w0_r[fag_pkg::CTRL_LSB-1:0], w1_r, w2_r, w3_r};

  // R6: mode only taken from flash at reset
  always_comb begin
    if (ctrl_code == fag_pkg::CODE_OPEN_ID) begin
      mode = (stored_id == fag_pkg::LOCK_ID) ? fag_pkg::MODE_LOCKED : fag_pkg::MODE_OPEN_ID;
    end else if (ctrl_code == fag_pkg::CODE_ERASE_FAIL) begin
      mode = fag_pkg::MODE_ERASE_FAIL;
    end else begin
      mode = fag_pkg::MODE_ERASE_ALWAYS;
    end
  end

  // R16: all fifteen bytes compared
  // R5: locked setting never matches
  // R10: host supplies the stored identifier
  logic id_match;
  assign id_match = loaded && (mode != fag_pkg::MODE_LOCKED) && (AUTH_ID == stored_id);

  // Authentication state
  fag_pkg::fag_boot_t bs_r, bs_nxt;
  fag_pkg::fag_dbg_t ds_r, ds_nxt;
  logic [1:0] fails_r, fails_nxt;
  logic done_r, done_nxt, ok_r, ok_nxt;
  logic [fag_pkg::EV_W-1:0] ev;
  logic boot_try, dbg_try;
  assign boot_try = AUTH_REQ && !AUTH_DBG && (bs_r == fag_pkg::BS_AUTH);
  assign dbg_try = AUTH_REQ && AUTH_DBG && (ds_r == fag_pkg::DS_AUTH);

  always_comb begin
    bs_nxt = bs_r;
    ds_nxt = ds_r;
    fails_nxt = fails_r;
    done_nxt = boot_try || dbg_try;
    ok_nxt = (boot_try || dbg_try) && id_match;
    ev = '0;
    case (bs_r)
      fag_pkg::BS_IDLE: begin
        // R11: authentication on boot connection
        if (loaded && BOOT_CONN) begin
          // R14: other codes erase without authentication
          if (mode == fag_pkg::MODE_ERASE_ALWAYS) begin
            bs_nxt = fag_pkg::BS_ERASE;
            ev[fag_pkg::EV_ERASE] = 1'b1;
          end else begin
            // R1: open-ID needs authentication
            bs_nxt = fag_pkg::BS_AUTH;
          end
        end
      end
      fag_pkg::BS_AUTH: begin
        if (!BOOT_CONN) begin
          bs_nxt = fag_pkg::BS_IDLE;
        end else if (boot_try) begin
          if (id_match) begin
            // R2: match opens flash rights
            bs_nxt = fag_pkg::BS_OPEN;
            fails_nxt = 2'h0;
          end else if (mode == fag_pkg::MODE_ERASE_FAIL && fails_r == fag_pkg::FAIL_LIMIT - 2'h1) begin
            // R15: third failure erases
            bs_nxt = fag_pkg::BS_ERASE;
            fails_nxt = 2'h0;
            ev[fag_pkg::EV_ERASE] = 1'b1;
          end else begin
            // R3: mismatch keeps awaiting
            fails_nxt = (mode == fag_pkg::MODE_ERASE_FAIL) ? fails_r + 2'h1 : 2'h0;
          end
        end
      end
      fag_pkg::BS_ERASE: begin
        if (ERASE_DONE) begin
          bs_nxt = BOOT_CONN ? fag_pkg::BS_OPEN : fag_pkg::BS_IDLE;
          ev[fag_pkg::EV_ERASED] = 1'b1;
        end
      end
      fag_pkg::BS_OPEN: begin
        if (!BOOT_CONN) begin
          bs_nxt = fag_pkg::BS_IDLE;
        end
      end
      default: begin
        bs_nxt = fag_pkg::BS_IDLE;
      end
    endcase
    case (ds_r)
      fag_pkg::DS_IDLE: begin
        // R12: authentication on debugger connection
        if (loaded && DBG_CONN) begin
          ds_nxt = fag_pkg::DS_AUTH;
        end
      end
      fag_pkg::DS_AUTH: begin
        // R4: debug link only after match
        if (!DBG_CONN) begin
          ds_nxt = fag_pkg::DS_IDLE;
        end else if (dbg_try && id_match) begin
          ds_nxt = fag_pkg::DS_OPEN;
        end
      end
      fag_pkg::DS_OPEN: begin
        if (!DBG_CONN) begin
          ds_nxt = fag_pkg::DS_IDLE;
        end
      end
      default: begin
        ds_nxt = fag_pkg::DS_IDLE;
      end
    endcase
    ev[fag_pkg::EV_PASS] = ok_nxt;
    ev[fag_pkg::EV_FAIL] = done_nxt && !ok_nxt;
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      bs_r <= fag_pkg::BS_IDLE;
      ds_r <= fag_pkg::DS_IDLE;
      fails_r <= 2'h0;
      done_r <= 1'b0;
      ok_r <= 1'b0;
    end else begin
      bs_r <= bs_nxt;
      ds_r <= ds_nxt;
      fails_r <= fails_nxt;
      done_r <= done_nxt;
      ok_r <= ok_nxt;
    end
  end

  assign AUTH_DONE = done_r;
  assign AUTH_OK = ok_r;
  assign BOOT_ACCESS = (bs_r == fag_pkg::BS_OPEN);
  assign DBG_LINK = (ds_r == fag_pkg::DS_OPEN);
  assign ERASE_REQ = (bs_r == fag_pkg::BS_ERASE);

  // Bus and software registers
  logic wr_pend_r, wr_pend_nxt, blk_r, blk_nxt;
  logic [7:0] wr_ofs_r, wr_ofs_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [fag_pkg::EV_W-1:0] ist_r, ist_nxt, ien_r, ien_nxt;
  logic [AW_W-1:0] aw_lo_r, aw_lo_nxt, aw_hi_r, aw_hi_nxt;
  logic aw_en_r, aw_en_nxt;
  logic take;
  assign take = HSEL && HTRANS[1] && HREADY;

  function automatic logic [31:0] reg_read(input logic [7:0] ofs, input logic [31:0] stat,
                                           input logic [fag_pkg::EV_W-1:0] ist, input logic [fag_pkg::EV_W-1:0] ien,
                                           input logic [AW_W-1:0] lo, input logic [AW_W-1:0] hi,
                                           input logic en, input logic [7:0] code);
    case (ofs)
      fag_pkg::OFS_STATUS: reg_read = stat;
      fag_pkg::OFS_IRQ_STAT: reg_read = 32'(ist);
      fag_pkg::OFS_IRQ_EN: reg_read = 32'(ien);
      fag_pkg::OFS_AW_START: reg_read = 32'(lo);
      fag_pkg::OFS_AW_END: reg_read = 32'(hi);
      fag_pkg::OFS_AW_CTRL: reg_read = {31'h0, en};
      fag_pkg::OFS_CTRL_CODE: reg_read = {24'h0, code};
      default: reg_read = 32'h0;
    endcase
  endfunction

  always_comb begin
    wr_pend_nxt = take && HWRITE;
    wr_ofs_nxt = take ? HADDR[7:0] : wr_ofs_r;
    rdata_nxt = rdata_r;
    if (take && !HWRITE) begin
      rdata_nxt = reg_read(HADDR[7:0],
                           {22'h0, fails_r, bs_r, 2'(ds_r), 2'(mode), loaded},
                           ist_r, ien_r, aw_lo_r, aw_hi_r, aw_en_r, ctrl_code);
    end
    ist_nxt = ist_r;
    ien_nxt = ien_r;
    aw_lo_nxt = aw_lo_r;
    aw_hi_nxt = aw_hi_r;
    aw_en_nxt = aw_en_r;
    if (wr_pend_r) begin
      case (wr_ofs_r)
        fag_pkg::OFS_IRQ_CLR: ist_nxt = ist_r & ~HWDATA[fag_pkg::EV_W-1:0];
        fag_pkg::OFS_IRQ_EN: ien_nxt = HWDATA[fag_pkg::EV_W-1:0];
        fag_pkg::OFS_AW_START: aw_lo_nxt = HWDATA[AW_W-1:0];
        fag_pkg::OFS_AW_END: aw_hi_nxt = HWDATA[AW_W-1:0];
        fag_pkg::OFS_AW_CTRL: aw_en_nxt = HWDATA[0];
        default: ist_nxt = ist_r;
      endcase
    end
    // Event set wins over clear
    ist_nxt = ist_nxt | ev;
    // R13: program and erase outside window blocked
    blk_nxt = aw_en_r && ((PE_ADDR < aw_lo_r) || (PE_ADDR >= aw_hi_r));
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r <= 8'h0;
      rdata_r <= 32'h0;
      ist_r <= '0;
      ien_r <= '0;
      aw_lo_r <= '0;
      aw_hi_r <= '0;
      aw_en_r <= 1'b0;
      blk_r <= 1'b0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_ofs_r <= wr_ofs_nxt;
      rdata_r <= rdata_nxt;
      ist_r <= ist_nxt;
      ien_r <= ien_nxt;
      aw_lo_r <= aw_lo_nxt;
      aw_hi_r <= aw_hi_nxt;
      aw_en_r <= aw_en_nxt;
      blk_r <= blk_nxt;
    end
  end

  assign HRDATA = rdata_r;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign PE_BLOCK = blk_r;
  assign IRQ = |(ist_r & ien_r);

endmodule
`default_nettype wire

// >>> test/fag_gate_monitor.sv
// Port assertions for the authentication gate
`default_nettype none
module fag_gate_monitor (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // Setting fetch
  input wire logic FLASH_RD_REQ,
  input wire logic [31:0] FLASH_RD_ADDR,
  input wire logic [31:0] FLASH_RD_DATA,
  input wire logic FLASH_RD_VALID,
  // Authentication
  input wire logic BOOT_CONN,
  input wire logic AUTH_REQ,
  input wire logic [119:0] AUTH_ID,
  input wire logic AUTH_DONE,
  input wire logic AUTH_OK,
  // Rights and erase
  input wire logic BOOT_ACCESS,
  input wire logic DBG_LINK,
  input wire logic ERASE_REQ,
  input wire logic ERASE_DONE
);
  logic [127:0] set_r, set_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [7:0] ctl;
  logic ld;
  assign ctl = set_r[127:120];
  assign ld = cnt_r == 3'h4;
  // Shadow of the loaded setting
  always_comb begin
    set_nxt = set_r;
    cnt_nxt = cnt_r;
    if (FLASH_RD_VALID && !ld) begin
      set_nxt[(3 - FLASH_RD_ADDR[3:2]) * 32 +: 32] = FLASH_RD_DATA;
      cnt_nxt = cnt_r + 3'h1;
    end
  end
  always_ff @(posedge CLOCK) begin
    set_r <= RESET_N ? set_nxt : '0;
    cnt_r <= RESET_N ? cnt_nxt : 3'h0;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  property p_fetch_addr;
    FLASH_RD_REQ |-> FLASH_RD_ADDR[31:4] == fag_pkg::SET_BASE[31:4];
  endproperty
  a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address off");
  property p_done_cause;
    AUTH_DONE |-> $past(AUTH_REQ);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("done without request");
  property p_access;
    $rose(BOOT_ACCESS) |-> (AUTH_DONE && AUTH_OK) || $past(ERASE_DONE) || $past(ERASE_DONE, 2);
  endproperty
  a_access: assert property (p_access) else $error("access without match");
  property p_dbg;
    $rose(DBG_LINK) |-> AUTH_DONE && AUTH_OK;
  endproperty
  a_dbg: assert property (p_dbg) else $error("link without match");
  property p_match;
    AUTH_DONE |-> AUTH_OK == ($past(AUTH_ID) == set_r[119:0]
      && !(ctl == fag_pkg::CODE_OPEN_ID && set_r[119:0] == fag_pkg::LOCK_ID));
  endproperty
  a_match: assert property (p_match) else $error("match result wrong");
  property p_erase_now;
    ld && ctl != fag_pkg::CODE_OPEN_ID && ctl != fag_pkg::CODE_ERASE_FAIL && $rose(BOOT_CONN) |-> ##[1:3] ERASE_REQ;
  endproperty
  a_erase_now: assert property (p_erase_now) else $error("no erase on connect");
  property p_erase_hold;
    ERASE_REQ && !ERASE_DONE |=> ERASE_REQ;
  endproperty
  a_erase_hold: assert property (p_erase_hold) else $error("erase dropped early");
  property p_no_erase_open;
    $rose(ERASE_REQ) |-> ctl != fag_pkg::CODE_OPEN_ID;
  endproperty
  a_no_erase_open: assert property (p_no_erase_open) else $error("erase in open mode");
endmodule
bind fag_gate fag_gate_monitor i_fag_gate_monitor (
  .CLOCK(CLOCK),
  .RESET_N(RESET_N),
  .FLASH_RD_REQ(FLASH_RD_REQ),
  .FLASH_RD_ADDR(FLASH_RD_ADDR),
  .FLASH_RD_DATA(FLASH_RD_DATA),
  .FLASH_RD_VALID(FLASH_RD_VALID),
  .BOOT_CONN(BOOT_CONN),
  .AUTH_REQ(AUTH_REQ),
  .AUTH_ID(AUTH_ID),
  .AUTH_DONE(AUTH_DONE),
  .AUTH_OK(AUTH_OK),
  .BOOT_ACCESS(BOOT_ACCESS),
  .DBG_LINK(DBG_LINK),
  .ERASE_REQ(ERASE_REQ),
  .ERASE_DONE(ERASE_DONE)
);
`default_nettype wire

// >>> test/fag_flash_model.sv
// Flash side model serving setting words and full erase
`default_nettype none
module fag_flash_model #(
  parameter int LAT = 2,
  parameter int ERASE_CYC = 6
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // Setting fetch
  input wire logic [127:0] setting,
  input wire logic FLASH_RD_REQ,
  input wire logic [31:0] FLASH_RD_ADDR,
  output logic [31:0] FLASH_RD_DATA,
  output logic FLASH_RD_VALID,
  // Full erase
  input wire logic ERASE_REQ,
  output logic ERASE_DONE
);
  int cnt = 0;
  int ecnt = 0;
  logic [1:0] idx = 2'h0;
  always @(posedge CLOCK) begin
    FLASH_RD_VALID <= 1'b0;
    ERASE_DONE <= 1'b0;
    FLASH_RD_DATA <= RESET_N ? ~FLASH_RD_DATA : 32'h0;
    ecnt <= ERASE_REQ ? ecnt + 1 : 0;
    if (ecnt == ERASE_CYC) begin
      ERASE_DONE <= 1'b1;
      ecnt <= 0;
    end
    if (!RESET_N) cnt <= 0;
    else if (FLASH_RD_REQ) begin
      cnt <= LAT;
      idx <= FLASH_RD_ADDR[3:2];
    end else if (cnt == 1) begin
      FLASH_RD_VALID <= 1'b1;
      FLASH_RD_DATA <= setting[(3 - idx) * 32 +: 32];
      cnt <= 0;
    end else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

// >>> test/test_fag_gate.sv
// Self-checking bench for the authentication gate
`default_nettype none
module test_fag_gate;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK = 0, RESET_N = 0, HSEL = 0, HWRITE = 0, HREADY, HREADYOUT, HRESP;
  logic BOOT_CONN = 0, DBG_CONN = 0, AUTH_REQ = 0, AUTH_DBG = 0, AUTH_DONE, AUTH_OK;
  logic FLASH_RD_REQ, FLASH_RD_VALID, BOOT_ACCESS, DBG_LINK, ERASE_REQ, ERASE_DONE, PE_BLOCK, IRQ;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HADDR = 0, HWDATA = 0, PE_ADDR = 0, HRDATA, FLASH_RD_ADDR, FLASH_RD_DATA, rd;
  logic [119:0] AUTH_ID = 0;
  logic [127:0] setting = 0;
  localparam logic [119:0] ID = 120'h0102030405060708090a0b0c0d0e0f;
  int n_mismatch = 0, compares = 0;
  assign HREADY = HREADYOUT;
  always #50 CLOCK = ~CLOCK;
  fag_gate i_fag_gate (
    .CLOCK(CLOCK), .RESET_N(RESET_N),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .FLASH_RD_REQ(FLASH_RD_REQ), .FLASH_RD_ADDR(FLASH_RD_ADDR), .FLASH_RD_DATA(FLASH_RD_DATA),
    .FLASH_RD_VALID(FLASH_RD_VALID),
    .BOOT_CONN(BOOT_CONN), .DBG_CONN(DBG_CONN), .AUTH_REQ(AUTH_REQ), .AUTH_DBG(AUTH_DBG), .AUTH_ID(AUTH_ID),
    .AUTH_DONE(AUTH_DONE), .AUTH_OK(AUTH_OK),
    .BOOT_ACCESS(BOOT_ACCESS), .DBG_LINK(DBG_LINK), .ERASE_REQ(ERASE_REQ), .ERASE_DONE(ERASE_DONE),
    .PE_ADDR(PE_ADDR), .PE_BLOCK(PE_BLOCK),
    .IRQ(IRQ)
  );
  fag_flash_model i_fag_flash_model (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .setting(setting),
    .FLASH_RD_REQ(FLASH_RD_REQ), .FLASH_RD_ADDR(FLASH_RD_ADDR), .FLASH_RD_DATA(FLASH_RD_DATA),
    .FLASH_RD_VALID(FLASH_RD_VALID),
    .ERASE_REQ(ERASE_REQ), .ERASE_DONE(ERASE_DONE)
  );
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    HSEL <= 1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i <= 20; i++) begin
        if (i == 20) begin
          n_mismatch++;
          print_verdict();
        end
        @(posedge CLOCK);
        if (HREADYOUT === 1'b1) break;
      end
      HSEL <= 0;
      HTRANS <= 2'h0;
      HWDATA <= d;
    end
    rd = HRDATA;
  endtask
  task automatic await(input bit erase);
    for (int i = 0; i <= 50; i++) begin
      if (i == 50) begin
        n_mismatch++;
        print_verdict();
      end
      @(posedge CLOCK);
      if ((erase ? ERASE_REQ : BOOT_ACCESS) === 1'b1) break;
    end
  endtask
  task automatic start(input logic [127:0] s);
    @(posedge CLOCK);
    RESET_N <= 0;
    BOOT_CONN <= 0;
    DBG_CONN <= 0;
    setting <= s;
    tick(5);
    RESET_N <= 1;
    for (int i = 0; i <= 20; i++) begin
      if (i == 20) begin
        n_mismatch++;
        print_verdict();
      end
      ahb(0, fag_pkg::OFS_STATUS, 0);
      if (rd[0] === 1'b1) break;
    end
  endtask
  task automatic auth(input logic dbg, input logic [119:0] id, input logic ok);
    @(posedge CLOCK);
    AUTH_REQ <= 1;
    AUTH_DBG <= dbg;
    AUTH_ID <= id;
    @(posedge CLOCK);
    AUTH_REQ <= 0;
    #1;
    chk("done", 1, AUTH_DONE);
    chk("ok", {31'h0, ok}, AUTH_OK);
  endtask
  task automatic t_open();
    logic [31:0] pa[3] = '{32'hff, 32'h100, 32'h200};
    start({fag_pkg::CODE_OPEN_ID, ID});
    chk("status", 32'h5, rd & 32'h7);
    ahb(0, fag_pkg::OFS_CTRL_CODE, 0);
    chk("code", 32'h52, rd);
    ahb(1, fag_pkg::OFS_IRQ_EN, 32'h2);
    BOOT_CONN <= 1;
    tick(2);
    auth(0, ID ^ 120'h1, 0);
    chk("access", 0, BOOT_ACCESS);
    chk("erase", 0, ERASE_REQ);
    tick(1);
    chk("irq", 1, IRQ);
    ahb(1, fag_pkg::OFS_IRQ_CLR, 32'hf);
    tick(1);
    chk("irq", 0, IRQ);
    auth(0, ID, 1);
    chk("access", 1, BOOT_ACCESS);
    tick(1);
    chk("irq", 0, IRQ);
    DBG_CONN <= 1;
    tick(2);
    auth(1, ~ID, 0);
    chk("link", 0, DBG_LINK);
    auth(1, ID, 1);
    chk("link", 1, DBG_LINK);
    ahb(0, 8'h40, 0);
    chk("unmapped", 0, rd);
    ahb(1, fag_pkg::OFS_AW_START, 32'h100);
    ahb(1, fag_pkg::OFS_AW_END, 32'h200);
    ahb(1, fag_pkg::OFS_AW_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      PE_ADDR <= pa[i];
      tick(2);
      chk("block", {31'h0, i != 1}, PE_BLOCK);
    end
  endtask
  task automatic t_lock();
    start({fag_pkg::CODE_OPEN_ID, fag_pkg::LOCK_ID});
    chk("status", 32'h7, rd & 32'h7);
    BOOT_CONN <= 1;
    DBG_CONN <= 1;
    tick(2);
    auth(0, fag_pkg::LOCK_ID, 0);
    auth(1, fag_pkg::LOCK_ID, 0);
    chk("access", 0, BOOT_ACCESS);
    chk("link", 0, DBG_LINK);
  endtask
  task automatic t_fail();
    start(128'h45010203_04050607_08090a0b_0c0d0e0f);
    chk("status", 32'h3, rd & 32'h7);
    ahb(1, fag_pkg::OFS_IRQ_EN, 32'h4);
    BOOT_CONN <= 1;
    tick(2);
    for (int i = 0; i < 3; i++) begin
      if (i < 2) chk("erase", 0, ERASE_REQ);
      auth(0, ~ID, 0);
    end
    await(1);
    chk("erase", 1, ERASE_REQ);
    chk("irq", 1, IRQ);
    await(0);
    chk("access", 1, BOOT_ACCESS);
  endtask
  task automatic t_other();
    start({8'h00, ID});
    chk("status", 32'h1, rd & 32'h7);
    BOOT_CONN <= 1;
    await(1);
    chk("access", 0, BOOT_ACCESS);
    DBG_CONN <= 1;
    tick(2);
    auth(1, ID, 1);
    chk("link", 1, DBG_LINK);
  endtask
  initial begin
    t_open();
    t_lock();
    t_fail();
    t_other();
    print_verdict();
  end
endmodule
`default_nettype wire
